// [rtl/dco_identify_pkg.sv]
// Purpose: Shared constants and types for the overlay identify responder
// Assumes: One 250 MHz clock, synchronous active-low resets
// Notes:   Register offsets are byte addresses on the plain register port
package dco_identify_pkg;

    // ------------------------------------------------------------------
    // Command decoding
    // ------------------------------------------------------------------
    localparam logic [7:0]  CMD_CONFIG_OVERLAY = 8'hB1;
    localparam logic [7:0]  SUB_IDENTIFY       = 8'h02;

    // ------------------------------------------------------------------
    // Capability structure contents
    // ------------------------------------------------------------------
    localparam logic [15:0] WORD_REVISION   = 16'h0001;
    localparam logic [15:0] WORD_MWDMA      = 16'h0007;
    localparam logic [15:0] WORD_UDMA       = 16'h003F;
    localparam logic [15:0] WORD_FEATURES   = 16'h008F;
    localparam logic [15:0] WORD_RESERVED   = 16'h0000;
    localparam logic [7:0]  SIGNATURE       = 8'hA5;
    localparam logic [63:0] MAX_LBA_LARGE   = 64'h0000_0000_04A8_52FF;
    localparam logic [63:0] MAX_LBA_SMALL   = 64'h0000_0000_0254_297F;
    localparam logic [7:0]  IDX_REVISION    = 8'h00;
    localparam logic [7:0]  IDX_MWDMA       = 8'h01;
    localparam logic [7:0]  IDX_UDMA        = 8'h02;
    localparam logic [7:0]  IDX_LBA_FIRST   = 8'h03;
    localparam logic [7:0]  IDX_LBA_LAST    = 8'h06;
    localparam logic [7:0]  IDX_FEATURES    = 8'h07;
    localparam logic [7:0]  IDX_LAST        = 8'hFF;
    localparam logic [8:0]  WORD_COUNT      = 9'h100;

    // ------------------------------------------------------------------
    // Register map and fields
    // ------------------------------------------------------------------
    localparam logic [3:0]  REG_STATUS      = 4'h0;
    localparam logic [3:0]  REG_MASK        = 4'h4;
    localparam logic [3:0]  REG_STATE       = 4'h8;
    localparam logic [3:0]  REG_CTRL        = 4'hC;
    localparam int          EV_DONE         = 0;
    localparam int          EV_ABORT        = 1;
    localparam int          ST_FROZEN_POS   = 0;
    localparam int          ST_BUSY_POS     = 1;
    localparam int          ST_DRQ_POS      = 2;
    localparam int          ST_ABORT_POS    = 3;
    localparam int          ST_INDEX_POS    = 8;
    localparam logic [1:0]  MASK_RESET      = 2'h0;
    localparam logic        CTRL_RESET      = 1'b1;

    // Task-file fields that this block looks at
    typedef struct packed {
        logic [7:0] code;
        logic [7:0] features;
        logic       drive_select_bit;
    } taskfile_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_FETCH = 2'b01,
        ST_XFER  = 2'b10
    } xfer_state_type;

endpackage : dco_identify_pkg

// [rtl/overlay_word_rom.sv]
// Purpose: Constant 256-word capability structure with registered read data
// Assumes: Address is held steady for one cycle before data is used
// Notes:   Integrity byte is worked out at elaboration from the other words
module overlay_word_rom
    import dco_identify_pkg::*;
#(
    parameter bit LARGE_CAPACITY = 1'b1
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Read port
    input  wire logic [7:0]  addr_i,
    output logic      [15:0] q_o
);

    localparam logic [63:0] MAX_LBA = LARGE_CAPACITY ? MAX_LBA_LARGE : MAX_LBA_SMALL;

    // ------------------------------------------------------------------
    // Structure contents
    // ------------------------------------------------------------------
    // Words before the integrity word; full set, never overlay-reduced
    function automatic logic [15:0] plain_word(input logic [7:0] idx);
        logic [15:0] w;
        w = WORD_RESERVED;
        if (idx == IDX_REVISION) w = WORD_REVISION;
        if (idx == IDX_MWDMA)    w = WORD_MWDMA;
        if (idx == IDX_UDMA)     w = WORD_UDMA;
        if (idx >= IDX_LBA_FIRST && idx <= IDX_LBA_LAST)
            w = MAX_LBA[16*(idx-IDX_LBA_FIRST) +: 16];
        if (idx == IDX_FEATURES) w = WORD_FEATURES;
        return w;
    endfunction : plain_word

    // Byte sum of words 0..7 plus signature, negated
    function automatic logic [7:0] integrity_byte();
        logic [7:0] s;
        logic [15:0] w;
        s = SIGNATURE;
        for (int i = 0; i <= int'(IDX_FEATURES); i++) begin
            w = plain_word(8'(i));
            s = s + w[7:0] + w[15:8];
        end
        return 8'(-s);
    endfunction : integrity_byte

    localparam logic [15:0] WORD_INTEGRITY = {integrity_byte(), SIGNATURE};

    // Registered read data
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            q_o <= 16'h0000;
        end else if (addr_i == IDX_LAST) begin
            q_o <= WORD_INTEGRITY;
        end else begin
            q_o <= plain_word(addr_i);
        end
    end

endmodule : overlay_word_rom

// [rtl/host_reg_port.sv]
// Purpose: Register port with sticky event status, mask and interrupt
// Assumes: Read data is wanted one cycle after the read strobe
// Notes:   A status read clears it; an event in that cycle still sets
module host_reg_port
    import dco_identify_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        resetn_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // Block side
    input  wire logic [1:0]  events_i,
    input  wire logic [31:0] state_i,
    output logic             enable_o,
    output logic             irq_o
);

    logic [1:0] status_reg;
    logic [1:0] status_next;
    logic [1:0] mask_reg;

    // Sticky status, set wins over read clear
    always_comb begin
        status_next = status_reg;
        if (rd_i && addr_i == REG_STATUS) status_next = 2'h0;
        status_next = status_next | events_i;
    end

    // Status, mask, control and interrupt level
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            status_reg <= 2'h0;
            mask_reg   <= MASK_RESET;
            enable_o   <= CTRL_RESET;
            irq_o      <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_i && addr_i == REG_MASK) mask_reg <= wdata_i[1:0];
            if (wr_i && addr_i == REG_CTRL) enable_o <= wdata_i[0];
            irq_o <= |(status_next & (wr_i && addr_i == REG_MASK ? wdata_i[1:0] : mask_reg));
        end
    end

    // Read data, zero for unmapped offsets
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            unique case (addr_i)
                REG_STATUS: rdata_o <= {30'h0, status_reg};
                REG_MASK:   rdata_o <= {30'h0, mask_reg};
                REG_STATE:  rdata_o <= state_i;
                REG_CTRL:   rdata_o <= {31'h0, enable_o};
                default:    rdata_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule : host_reg_port

// [rtl/config_identify_responder.sv]
// Purpose: Device side of the configuration-overlay identify command
// Assumes: Task-file writes and data reads arrive synchronous to clk_i
// Notes:   Freeze state is cleared only by the power-on reset input
module config_identify_responder
    import dco_identify_pkg::*;
#(
    parameter bit LARGE_CAPACITY = 1'b1
) (
    // Clock and resets
    input  wire logic         clk_i,
    input  wire logic         resetn_i,
    input  wire logic         power_on_resetn_i,
    // Drive identity
    input  wire logic         own_drive_i,
    // Task-file command
    input  wire logic         cmd_valid_i,
    input  wire taskfile_type cmd_i,
    input  wire logic         freeze_lock_done_i,
    // PIO data-in
    input  wire logic         data_read_i,
    output logic      [15:0]  data_o,
    output logic              drq_o,
    output logic              busy_o,
    output logic              abort_o,
    // Register port
    input  wire logic [3:0]   reg_addr_i,
    input  wire logic [31:0]  reg_wdata_i,
    input  wire logic         reg_wr_i,
    input  wire logic         reg_rd_i,
    output logic      [31:0]  reg_rdata_o,
    output logic              irq_o
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    xfer_state_type state_reg;
    xfer_state_type state_next;
    logic [7:0]     word_idx_reg;
    logic           frozen_reg;
    logic           ev_done_reg;
    logic           ev_abort_reg;
    logic           enable;
    logic           accept;
    logic           start_ok;
    logic           start_abort;
    logic           word_taken;
    logic           last_taken;
    logic [31:0]    state_word;

    // Identify request pattern in the task file
    function automatic logic is_identify(input taskfile_type tf);
        return tf.code == CMD_CONFIG_OVERLAY && tf.features == SUB_IDENTIFY;
    endfunction : is_identify

    // Request aimed at this drive
    function automatic logic for_this_drive(input taskfile_type tf, input logic own);
        return tf.drive_select_bit == own;
    endfunction : for_this_drive

    // ------------------------------------------------------------------
    // Command acceptance
    // ------------------------------------------------------------------
    // Only an idle, enabled, selected drive takes the request
    assign accept      = cmd_valid_i && is_identify(cmd_i)
                         && for_this_drive(cmd_i, own_drive_i)
                         && enable && state_reg == ST_IDLE;
    assign start_ok    = accept && !frozen_reg;
    assign start_abort = accept && frozen_reg;
    assign word_taken  = state_reg == ST_XFER && data_read_i;
    assign last_taken  = word_taken && word_idx_reg == IDX_LAST;

    // Freeze flag, cleared only by power-on reset
    always_ff @(posedge clk_i) begin
        if (!power_on_resetn_i) begin
            frozen_reg <= 1'b0;
        end else if (freeze_lock_done_i) begin
            frozen_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Transfer sequencing
    // ------------------------------------------------------------------
    // Next state: fetch a word, offer it, wait for the host to take it
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_ok) state_next = ST_FETCH;
            end
            ST_FETCH: begin
                state_next = ST_XFER;
            end
            ST_XFER: begin
                if (last_taken) begin
                    state_next = ST_IDLE;
                end else if (word_taken) begin
                    state_next = ST_FETCH;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Word index walks 0..255 in order
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            word_idx_reg <= 8'h00;
        end else if (start_ok) begin
            word_idx_reg <= 8'h00;
        end else if (word_taken && !last_taken) begin
            word_idx_reg <= word_idx_reg + 8'h01;
        end
    end

    // Status outputs: busy while fetching, request while a word stands
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            drq_o  <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            drq_o  <= state_next == ST_XFER;
            busy_o <= state_next == ST_FETCH;
        end
    end

    // Abort status, held until the next accepted request
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            abort_o <= 1'b0;
        end else if (start_abort) begin
            abort_o <= 1'b1;
        end else if (start_ok) begin
            abort_o <= 1'b0;
        end
    end

    // One-cycle completion events for the status register
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ev_done_reg  <= 1'b0;
            ev_abort_reg <= 1'b0;
        end else begin
            ev_done_reg  <= last_taken;
            ev_abort_reg <= start_abort;
        end
    end

    // ------------------------------------------------------------------
    // Structure store and register port
    // ------------------------------------------------------------------
    overlay_word_rom #(
        .LARGE_CAPACITY (LARGE_CAPACITY)
    ) u_rom (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .addr_i   (word_idx_reg),
        .q_o      (data_o)
    );

    // Software-visible state of the block
    always_comb begin
        state_word                = 32'h0000_0000;
        state_word[ST_FROZEN_POS] = frozen_reg;
        state_word[ST_BUSY_POS]   = busy_o;
        state_word[ST_DRQ_POS]    = drq_o;
        state_word[ST_ABORT_POS]  = abort_o;
        state_word[ST_INDEX_POS +: 8] = word_idx_reg;
    end

    host_reg_port u_regs (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .addr_i   (reg_addr_i),
        .wdata_i  (reg_wdata_i),
        .wr_i     (reg_wr_i),
        .rd_i     (reg_rd_i),
        .rdata_o  (reg_rdata_o),
        .events_i ({ev_abort_reg, ev_done_reg}),
        .state_i  (state_word),
        .enable_o (enable),
        .irq_o    (irq_o)
    );

    // ------------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------------
    logic [8:0] read_count_reg;
    logic [7:0] byte_sum_reg;

    // Words taken and their running byte sum in the current transfer
    always_ff @(posedge clk_i) begin
        if (!resetn_i || start_ok) begin
            read_count_reg <= 9'h000;
            byte_sum_reg   <= 8'h00;
        end else if (word_taken) begin
            read_count_reg <= read_count_reg + 9'h001;
            byte_sum_reg   <= byte_sum_reg + data_o[7:0] + data_o[15:8];
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_decode_start: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_reg == ST_IDLE && cmd_valid_i && enable && !frozen_reg
         && for_this_drive(cmd_i, own_drive_i) && !is_identify(cmd_i))
        |=> state_reg == ST_IDLE)
        else $error("non-identify command started a transfer");

    a_other_drive: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (state_reg == ST_IDLE && cmd_valid_i && cmd_i.drive_select_bit != own_drive_i)
        |=> state_reg == ST_IDLE && !abort_o == !$past(abort_o))
        else $error("request for the other drive was acted on");

    a_drq_follows: assert property (@(posedge clk_i) disable iff (!resetn_i)
        start_ok |=> busy_o ##1 drq_o && !busy_o && data_o == WORD_REVISION)
        else $error("data request did not follow acceptance");

    a_word_count: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ev_done_reg |-> read_count_reg == WORD_COUNT && !drq_o && !abort_o)
        else $error("transfer did not end after 256 words");

    a_frozen_abort: assert property (@(posedge clk_i) disable iff (!resetn_i)
        start_abort |=> abort_o && !drq_o && !busy_o ##1 !drq_o)
        else $error("frozen device did not abort");

    a_freeze_holds: assert property (@(posedge clk_i)
        disable iff (!power_on_resetn_i)
        frozen_reg |=> frozen_reg)
        else $error("freeze lock lost before power cycle");

    a_reserved_words: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (drq_o && word_idx_reg > IDX_FEATURES && word_idx_reg < IDX_LAST)
        |-> data_o == WORD_RESERVED)
        else $error("reserved word not zero");

    a_mode_words: assert property (@(posedge clk_i) disable iff (!resetn_i)
        drq_o |-> (word_idx_reg != IDX_MWDMA || data_o == WORD_MWDMA)
              && (word_idx_reg != IDX_UDMA || data_o == WORD_UDMA))
        else $error("DMA mode word wrong");

    a_lba_words: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (drq_o && word_idx_reg == IDX_LBA_FIRST) |-> data_o
        == (LARGE_CAPACITY ? MAX_LBA_LARGE[15:0] : MAX_LBA_SMALL[15:0]))
        else $error("lowest LBA word wrong");

    a_feature_word: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (drq_o && word_idx_reg == IDX_FEATURES) |-> data_o == WORD_FEATURES)
        else $error("feature-set word wrong");

    a_signature: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (drq_o && word_idx_reg == IDX_LAST) |-> data_o[7:0] == SIGNATURE)
        else $error("integrity signature wrong");

    a_byte_sum: assert property (@(posedge clk_i) disable iff (!resetn_i)
        ev_done_reg |-> byte_sum_reg == 8'h00)
        else $error("structure byte sum not zero");

    // Top LBA word is always zero
    a_lba_upper: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (drq_o && word_idx_reg == IDX_LBA_LAST)
        |-> data_o == WORD_RESERVED)
        else $error("top LBA word not zero");

    // Word 0 carries the revision
    a_revision_word: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (drq_o && word_idx_reg == IDX_REVISION)
        |-> data_o == WORD_REVISION)
        else $error("revision word wrong");

    // Request and busy never together
    a_drq_busy_apart: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        !(drq_o && busy_o))
        else $error("drq and busy both high");

    // Aborted command moves no data
    a_abort_no_data: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        abort_o
        |-> !drq_o
        && !busy_o)
        else $error("data activity after abort");

    // Freeze pulse locks at the next edge
    a_frozen_sets: assert property (@(posedge clk_i)
        disable iff (!power_on_resetn_i)
        freeze_lock_done_i
        |=> frozen_reg)
        else $error("freeze lock not taken");

    // Each taken word except the last steps the index
    a_read_steps: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        (word_taken
        && !last_taken)
        |=> word_idx_reg == $past(word_idx_reg) + 8'h01)
        else $error("word index did not step");

    // Completion leaves the block idle
    a_done_idle: assert property (@(posedge clk_i)
        disable iff (!resetn_i)
        ev_done_reg
        |-> state_reg == ST_IDLE
        && word_idx_reg == IDX_LAST)
        else $error("block not idle after last word");

endmodule : config_identify_responder

// [testbench/host_pio_model.sv]
// Purpose: Host controller model issuing commands and reading PIO words
// Assumes: Drives change by non-blocking assignment after rising clk_i edges
// Notes:   A released command bus shows the inverse of its last value
module host_pio_model
    import dco_identify_pkg::*;
(
    // Clock and device side
    input  wire logic        clk_i,
    input  wire logic        drq_i,
    input  wire logic [15:0] data_i,
    // Host drives
    output logic             cmd_valid_o,
    output taskfile_type     cmd_o,
    output logic             data_read_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] got [256];
    int          nwords = 0;

    initial begin
        cmd_valid_o = 1'b0;
        cmd_o       = '0;
        data_read_o = 1'b0;
    end

    // One-cycle task-file write, then the bus is released
    task issue(input logic [7:0] c, input logic [7:0] f, input logic d);
        @(posedge clk_i);
        cmd_valid_o <= 1'b1;
        cmd_o       <= '{code: c, features: f, drive_select_bit: d};
        @(posedge clk_i);
        cmd_valid_o <= 1'b0;
        cmd_o       <= ~cmd_o;
    endtask : issue

    // Read words in order, waiting gap cycles after each request appears
    task read_block(input int gap, input int limit);
        int idle;
        idle   = 0;
        nwords = 0;
        while (nwords < 256 && limit > 0) begin
            @(posedge clk_i);
            limit--;
            if (drq_i && data_read_o) begin
                got[nwords] = data_i;
                nwords++;
                data_read_o <= 1'b0;
                idle = 0;
            end else if (drq_i && idle >= gap && limit > 0) begin
                data_read_o <= 1'b1;
            end else if (drq_i) begin
                idle++;
            end
        end
    endtask : read_block
endmodule : host_pio_model

// [testbench/testbench.sv]
// Purpose: Self-checking bench for the overlay identify responder
// Assumes: Host model drives the command and PIO ports
// Notes:   Expected structure is rebuilt here with integer arithmetic
module testbench
    import dco_identify_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_i, resetn_i, power_on_resetn_i, own_drive_i, freeze_lock_done_i;
    logic         reg_wr_i, reg_rd_i, cmd_valid_i, data_read_i, drq_o, busy_o, abort_o, irq_o;
    logic [3:0]   reg_addr_i;
    logic [31:0]  reg_wdata_i, reg_rdata_o, rd, lfsr_reg;
    logic [15:0]  data_o;
    logic [15:0]  exp_w [256];
    taskfile_type cmd_i;
    int           err_total, cmp_count, cycle_count;

    host_pio_model i_host (.clk_i, .drq_i(drq_o), .data_i(data_o),
        .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i), .data_read_o(data_read_i));
    config_identify_responder #(.LARGE_CAPACITY(1'b1)) i_dut (.clk_i, .resetn_i,
        .power_on_resetn_i, .own_drive_i, .cmd_valid_i, .cmd_i, .freeze_lock_done_i,
        .data_read_i, .data_o, .drq_o, .busy_o, .abort_o, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .irq_o);

    // 250 MHz clock
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // Hang guard
    always @(posedge clk_i) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 20000) begin
            err_total++;
            conclude();
        end
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task conclude;
        if (err_total == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    task check_val(input string what, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask : check_val

    // Expected capability structure with its integrity byte
    task build_model;
        int sum;
        sum = 8'hA5;
        for (int i = 0; i < 256; i++) begin
            exp_w[i] = 16'h0000;
        end
        exp_w[0] = 16'h0001;
        exp_w[1] = 16'h0007;
        exp_w[2] = 16'h003F;
        exp_w[3] = 16'h52FF;
        exp_w[4] = 16'h04A8;
        exp_w[7] = 16'h008F;
        for (int i = 0; i < 255; i++) begin
            sum += exp_w[i][7:0] + exp_w[i][15:8];
        end
        exp_w[255] = {8'(256 - sum % 256), 8'hA5};
    endtask : build_model

    task reset_pulse(input logic por);
        @(posedge clk_i);
        resetn_i <= 1'b0;
        if (por) begin
            power_on_resetn_i <= 1'b0;
        end
        repeat (5) @(posedge clk_i);
        resetn_i          <= 1'b1;
        power_on_resetn_i <= 1'b1;
    endtask : reset_pulse

    task reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask : reg_write

    // Read data stand in the cycle after the strobe
    task reg_read(input logic [3:0] a);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(posedge clk_i);
        rd = reg_rdata_o;
    endtask : reg_read

    task reg_check(input logic [3:0] a, input logic [31:0] e);
        reg_read(a);
        check_val("register", e, rd);
    endtask : reg_check

    // Command that must move no data
    task expect_idle(input logic [7:0] c, input logic [7:0] f, input logic d);
        i_host.issue(c, f, d);
        repeat (3) begin
            #1;
            check_val("busy", 0, busy_o);
            check_val("drq", 0, drq_o);
            @(posedge clk_i);
        end
    endtask : expect_idle

    task check_block(input int gap);
        int sum;
        sum = 0;
        #1;
        check_val("busy", 1, busy_o);
        i_host.read_block(gap, 4000);
        check_val("word count", 256, i_host.nwords);
        for (int i = 0; i < 256; i++) begin
            check_val("word", exp_w[i], i_host.got[i]);
            sum += i_host.got[i][7:0] + i_host.got[i][15:8];
        end
        check_val("byte sum", 0, sum % 256);
        repeat (3) @(posedge clk_i);
        #1;
        check_val("drq after block", 0, drq_o);
        check_val("abort", 0, abort_o);
    endtask : check_block

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        resetn_i           = 1'b0;
        power_on_resetn_i  = 1'b0;
        own_drive_i        = 1'b0;
        freeze_lock_done_i = 1'b0;
        reg_wr_i           = 1'b0;
        reg_rd_i           = 1'b0;
        reg_addr_i         = 4'h0;
        reg_wdata_i        = 32'h0;
        err_total          = 0;
        cmp_count          = 0;
        cycle_count        = 0;
        lfsr_reg           = 32'h0000_ACB2;
        build_model();
        reset_pulse(1'b1);
        reg_check(REG_STATUS, 32'h0);
        reg_check(REG_MASK, 32'h0);
        reg_check(REG_CTRL, 32'h1);
        reg_check(4'h2, 32'h0);
        for (int k = 0; k < 3; k++) begin
            expect_idle(8'hB1, 8'(k == 2 ? 3 : k), 1'b0);
        end
        lfsr_reg = lfsr_next(lfsr_reg);
        expect_idle((lfsr_reg[7:0] == 8'hB1) ? 8'h00 : lfsr_reg[7:0], 8'h02, 1'b0);
        expect_idle(8'hB1, 8'h02, 1'b1);
        reg_write(REG_CTRL, 32'h0);
        expect_idle(8'hB1, 8'h02, 1'b0);
        reg_write(REG_CTRL, 32'h1);
        // Prompt host, interrupt masked off
        i_host.issue(8'hB1, 8'h02, 1'b0);
        check_block(0);
        check_val("irq masked", 0, irq_o);
        reg_check(REG_STATUS, 32'h1);
        // Reset in mid-transfer drops the request
        i_host.issue(8'hB1, 8'h02, 1'b0);
        i_host.read_block(0, 30);
        reset_pulse(1'b0);
        #1;
        check_val("drq after reset", 0, drq_o);
        check_val("data after reset", 0, data_o);
        // Slow host with a random gap, interrupt enabled
        reg_write(REG_MASK, 32'h3);
        lfsr_reg = lfsr_next(lfsr_reg);
        i_host.issue(8'hB1, 8'h02, 1'b0);
        check_block(int'(lfsr_reg[1:0]) + 1);
        check_val("irq", 1, irq_o);
        reg_check(REG_STATUS, 32'h1);
        #1;
        check_val("irq cleared", 0, irq_o);
        // Freeze lock survives a plain reset and aborts the request
        @(posedge clk_i);
        freeze_lock_done_i <= 1'b1;
        @(posedge clk_i);
        freeze_lock_done_i <= 1'b0;
        reset_pulse(1'b0);
        reg_write(REG_MASK, 32'h2);
        expect_idle(8'hB1, 8'h02, 1'b0);
        @(posedge clk_i);
        #1;
        check_val("abort", 1, abort_o);
        check_val("irq abort", 1, irq_o);
        reg_check(REG_STATUS, 32'h2);
        reg_read(REG_STATE);
        check_val("state", 32'h9, rd & 32'h0000_000F);
        // Power-on reset clears the lock; the second drive answers
        reset_pulse(1'b1);
        own_drive_i <= 1'b1;
        expect_idle(8'hB1, 8'h02, 1'b0);
        i_host.issue(8'hB1, 8'h02, 1'b1);
        check_block(0);
        conclude();
    end
endmodule : testbench
